// [rtl/chop_consts.svh]
`ifndef CHOP_CONSTS_SVH
`define CHOP_CONSTS_SVH
// ----------------------------------------------------------------
// register map and field layout
// ----------------------------------------------------------------
`define CFG_ADDR      6'h05
`define CFG_RESET     8'h01
`define OFFT_MSB      7
`define OFFT_LSB      6
`define REGDIS_BIT    5
`define VSCL_MSB      4
`define VSCL_LSB      3
`define SH_BIT        2
`define GAIN_MSB      1
`define GAIN_LSB      0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define OFFT0_US      25
`define OFFT1_US      50
`define OFFT2_US      100
`define OFFT3_US      200
`define BLANK_NS      2000
`define US_TO_CYC(us) ((us) * 1000 / `CLK_PERIOD_NS)
`define NS_TO_CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [rtl/chop_pkg.sv]
`default_nettype none
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package chop_pkg;
  // cycle counts up to 200 us at 100 MHz
  typedef logic [14:0] cyc_type;
  // chopping sequencer states
  typedef enum logic [1:0] {
    DRIVE = 2'b00,  // bridge driven, waiting for a trip
    OFF   = 2'b01,  // fixed off time
    BLANK = 2'b10   // trip ignored after re-enabling drive
  } state_type;
endpackage : chop_pkg
`default_nettype wire

// [rtl/chop_timer_if.sv]
`default_nettype none
// ----------------------------------------------------------------
// link between the register bank and the chopping timer
// ----------------------------------------------------------------
interface chop_timer_if;
  chop_pkg::cyc_type off_cycles;   // programmed off time in cycles
  logic              enable;       // current regulation active
  logic              trip;         // chopping threshold reached
  logic              off_active;   // off time running
  logic              blank_active; // blanking running
  modport ctrl  (output off_cycles, enable, trip,
                 input  off_active, blank_active);
  modport timer (input  off_cycles, enable, trip,
                 output off_active, blank_active);
endinterface : chop_timer_if
`default_nettype wire

// [rtl/chop_off_timer.sv]
`include "chop_consts.svh"
`default_nettype none
// ----------------------------------------------------------------
// fixed off-time chopping sequencer
// ----------------------------------------------------------------
module chop_off_timer (
  input wire logic    clk_in,
  input wire logic    srst_in,
  chop_timer_if.timer tif
);
  localparam chop_pkg::cyc_type BLANK_CYC =
    15'(`NS_TO_CYC_UP(`BLANK_NS));
  localparam int unsigned BLANK_INT = `NS_TO_CYC_UP(`BLANK_NS);

  chop_pkg::state_type state_q;  // current phase
  chop_pkg::state_type state_d;  // next phase
  chop_pkg::cyc_type   cnt_q;    // cycles spent in phase
  chop_pkg::cyc_type   len_q;    // off time latched at trip
  logic                off_q;    // registered off flag
  logic                blank_q;  // registered blank flag

  // next phase; disabling regulation parks in drive
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      chop_pkg::DRIVE: if (tif.trip) state_d = chop_pkg::OFF; // [R7]
      chop_pkg::OFF:   if (cnt_q == len_q - 15'h1)
                         state_d = chop_pkg::BLANK; // [R7]
      chop_pkg::BLANK: if (cnt_q == BLANK_CYC - 15'h1)
                         state_d = chop_pkg::DRIVE; // [R7]
      default:         state_d = chop_pkg::DRIVE;
    endcase
    if (!tif.enable) state_d = chop_pkg::DRIVE;
  end

  // phase register and its decoded flags
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= chop_pkg::DRIVE;
      off_q   <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      state_q <= state_d;
      off_q   <= (state_d == chop_pkg::OFF);
      blank_q <= (state_d == chop_pkg::BLANK);
    end
  end

  // phase counter restarts on every change of phase
  always_ff @(posedge clk_in) begin
    if (srst_in || state_d != state_q) cnt_q <= 15'h0;
    else                               cnt_q <= cnt_q + 15'h1;
  end

  // off time sampled at trip so a rewrite only hits the next chop
  always_ff @(posedge clk_in) begin
    if (srst_in) len_q <= 15'h1;
    else if (state_q == chop_pkg::DRIVE) len_q <= tif.off_cycles;
  end

  assign tif.off_active   = off_q;
  assign tif.blank_active = blank_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // whole off+blank span, measured from trip acceptance
  chop_pkg::cyc_type span_q;
  always_ff @(posedge clk_in) begin
    if (srst_in || state_q == chop_pkg::DRIVE) span_q <= 15'h0;
    else                                       span_q <= span_q + 15'h1;
  end

  sequence s_trip_taken;
    state_q == chop_pkg::DRIVE && tif.enable && tif.trip;
  endsequence
  sequence s_off_entered;
    off_q && !blank_q;
  endsequence

  property p_trip_starts_off;
    @(posedge clk_in) disable iff (srst_in)
      s_trip_taken |=> s_off_entered;
  endproperty
  a_trip_starts_off: assert property (p_trip_starts_off) // [R7]
    else $error("trip did not start the off time");

  property p_chop_period;
    @(posedge clk_in) disable iff (srst_in)
      (state_q == chop_pkg::BLANK && state_d == chop_pkg::DRIVE
       && tif.enable)
      |-> (32'(span_q) + 32'd1 == 32'(len_q) + BLANK_INT);
  endproperty
  a_chop_period: assert property (p_chop_period) // [R7]
    else $error("chop cycle shorter or longer than off plus blank");

  property p_blank_ignores_trip;
    @(posedge clk_in) disable iff (srst_in)
      (state_q == chop_pkg::BLANK && cnt_q == 15'h0)
      |-> !off_q [*2];
  endproperty
  a_blank_ignores_trip: assert property (p_blank_ignores_trip) // [R7]
    else $error("off time restarted during blanking");
endmodule : chop_off_timer
`default_nettype wire

// [rtl/chopper_amp_config_register.sv]
`include "chop_consts.svh"
`default_nettype none
// Summary of operation
// (R1) read/write configuration register at address 0x05
// (R2) bits 7:6 pick off time 25-200us
// (R3) bit 5 set disables current regulation
// (R4) bits 4:3 scale reference 100/75/50/25%
// (R5) bit 2 enables amplifier sample and hold
// (R6) bits 1:0 set amplifier gain, reset 01b
// (R7) chop cycle lasts off time plus blanking
// (R8) host sets overcurrent threshold in other register
// (R9) reset loads 0x01; reads return written value
module chopper_amp_config_register #(
  // off-time counts; shorten for simulation
  parameter int unsigned OFF0_CYC = `US_TO_CYC(`OFFT0_US),
  parameter int unsigned OFF1_CYC = `US_TO_CYC(`OFFT1_US),
  parameter int unsigned OFF2_CYC = `US_TO_CYC(`OFFT2_US),
  parameter int unsigned OFF3_CYC = `US_TO_CYC(`OFFT3_US)
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [5:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output var  logic [7:0] reg_rdata_out,
  output var  logic       reg_rvalid_out,
  input  wire logic       chop_trip_in,
  output var  logic [1:0] chop_off_time_out,
  output var  logic       regulation_disable_out,
  output var  logic [1:0] vref_scale_out,
  output var  logic       amp_sample_hold_enable_out,
  output var  logic [1:0] amp_gain_out,
  output var  logic       chop_off_active_out,
  output var  logic       chop_blank_active_out
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]        cfg_q;      // the configuration register
  logic [7:0]        rdata_q;    // read data holding register
  logic              rvalid_q;   // read answer strobe
  chop_pkg::cyc_type off_cyc;    // decoded off time in cycles
  logic              hit_cfg;    // address matches this register

  chop_timer_if tif ();

  // only one address lives here; all others decode as unmapped
  assign hit_cfg = (reg_addr_in == `CFG_ADDR); // [R1]

  // ----------------------------------------------------------------
  // register write
  // ----------------------------------------------------------------
  // whole byte written at once; writes elsewhere are dropped
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cfg_q <= `CFG_RESET; // [R9] [R6]
    end else if (reg_wr_in && hit_cfg) begin
      cfg_q <= reg_wdata_in; // [R1] [R9]
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // one-cycle latency answer; unmapped reads return zero so the
  // host never sees stale data from a previous access
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= hit_cfg ? cfg_q : 8'h00; // [R1] [R9]
      end
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ----------------------------------------------------------------
  // field outputs, taken straight off the register
  // ----------------------------------------------------------------
  assign chop_off_time_out          = cfg_q[`OFFT_MSB:`OFFT_LSB]; // [R2]
  assign regulation_disable_out     = cfg_q[`REGDIS_BIT];         // [R3]
  assign vref_scale_out             = cfg_q[`VSCL_MSB:`VSCL_LSB]; // [R4]
  assign amp_sample_hold_enable_out = cfg_q[`SH_BIT];             // [R5]
  assign amp_gain_out               = cfg_q[`GAIN_MSB:`GAIN_LSB]; // [R6]

  // ----------------------------------------------------------------
  // off-time decode
  // ----------------------------------------------------------------
  // every field code is legal, so no default arm is needed
  always_comb begin
    unique case (cfg_q[`OFFT_MSB:`OFFT_LSB])
      2'h0: off_cyc = 15'(OFF0_CYC); // [R2]
      2'h1: off_cyc = 15'(OFF1_CYC); // [R2]
      2'h2: off_cyc = 15'(OFF2_CYC); // [R2]
      2'h3: off_cyc = 15'(OFF3_CYC); // [R2]
    endcase
  end

  // ----------------------------------------------------------------
  // chopping timer
  // ----------------------------------------------------------------
  // disable bit clears the timer enable; trip passes straight through and the timer parks in drive
  assign tif.off_cycles = off_cyc;
  assign tif.enable     = !cfg_q[`REGDIS_BIT]; // [R3]
  assign tif.trip       = chop_trip_in;

  chop_off_timer u_timer (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .tif     (tif)
  );

  // timer flags are flops inside the timer
  assign chop_off_active_out   = tif.off_active;
  assign chop_blank_active_out = tif.blank_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cfg_write;
    reg_wr_in && hit_cfg;
  endsequence

  property p_cfg_write;
    @(posedge clk_in) disable iff (srst_in)
      s_cfg_write |=> cfg_q == $past(reg_wdata_in);
  endproperty
  a_cfg_write: assert property (p_cfg_write) // [R1]
    else $error("write to config register not stored");

  property p_unmapped_write;
    @(posedge clk_in) disable iff (srst_in)
      (reg_wr_in && !hit_cfg) |=> $stable(cfg_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) // [R1]
    else $error("write to other address changed config");

  property p_read_back;
    @(posedge clk_in) disable iff (srst_in)
      (s_cfg_write ##1 (reg_rd_in && hit_cfg && !reg_wr_in))
      |=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_read_back: assert property (p_read_back) // [R9]
    else $error("read did not return the value written");

  property p_reset_value;
    @(posedge clk_in) disable iff (srst_in)
      $fell(srst_in) |-> cfg_q == `CFG_RESET && amp_gain_out == 2'h1;
  endproperty
  a_reset_value: assert property (p_reset_value) // [R9]
    else $error("config not at reset value after reset");

  property p_off_field;
    @(posedge clk_in) disable iff (srst_in)
      s_cfg_write |=> chop_off_time_out ==
        $past(reg_wdata_in[`OFFT_MSB:`OFFT_LSB]);
  endproperty
  a_off_field: assert property (p_off_field) // [R2]
    else $error("off time field not updated");

  property p_off_len;
    @(posedge clk_in) disable iff (srst_in)
      ((chop_off_time_out == 2'h0) |-> off_cyc == 15'(OFF0_CYC))
      and ((chop_off_time_out == 2'h1) |-> off_cyc == 15'(OFF1_CYC))
      and ((chop_off_time_out == 2'h2) |-> off_cyc == 15'(OFF2_CYC))
      and ((chop_off_time_out == 2'h3) |-> off_cyc == 15'(OFF3_CYC));
  endproperty
  a_off_len: assert property (p_off_len) // [R2]
    else $error("off time code decodes to wrong count");

  property p_reg_disable;
    @(posedge clk_in) disable iff (srst_in)
      regulation_disable_out |=> !chop_off_active_out
                                 && !chop_blank_active_out;
  endproperty
  a_reg_disable: assert property (p_reg_disable) // [R3]
    else $error("chopping while regulation disabled");

  property p_vref_field;
    @(posedge clk_in) disable iff (srst_in)
      s_cfg_write |=> vref_scale_out ==
        $past(reg_wdata_in[`VSCL_MSB:`VSCL_LSB]);
  endproperty
  a_vref_field: assert property (p_vref_field) // [R4]
    else $error("reference scale field not updated");

  property p_sh_field;
    @(posedge clk_in) disable iff (srst_in)
      s_cfg_write |=> amp_sample_hold_enable_out ==
        $past(reg_wdata_in[`SH_BIT]);
  endproperty
  a_sh_field: assert property (p_sh_field) // [R5]
    else $error("sample and hold bit not updated");

  property p_gain_field;
    @(posedge clk_in) disable iff (srst_in)
      s_cfg_write |=> amp_gain_out ==
        $past(reg_wdata_in[`GAIN_MSB:`GAIN_LSB]);
  endproperty
  a_gain_field: assert property (p_gain_field) // [R6]
    else $error("gain field not updated");

  // unmapped reads still answer, but never with stale data
  property p_unmapped_read;
    @(posedge clk_in) disable iff (srst_in)
      (reg_rd_in && !hit_cfg) |=> reg_rvalid_out && reg_rdata_out == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // [R1]
    else $error("unmapped read did not answer zero");

  // answer strobe only ever follows a read strobe
  property p_rvalid_pulse;
    @(posedge clk_in) disable iff (srst_in)
      !reg_rd_in |=> !reg_rvalid_out;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) // [R1]
    else $error("read answer without a read");
endmodule : chopper_amp_config_register
`default_nettype wire

// [tb/chop_host.sv]
`default_nettype none
// ------------------------------------------------------------
// host controller model on the config register port
// ------------------------------------------------------------
module chop_host (
  input  wire logic       clk_in,     // device clock
  output var  logic [5:0] addr_out,   // register address
  output var  logic       wr_out,     // write strobe
  output var  logic [7:0] wdata_out,  // write data
  output var  logic       rd_out,     // read strobe
  input  wire logic [7:0] rdata_in,   // read data
  input  wire logic       rvalid_in   // read answer
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus starts on a pattern, not on zero
  initial begin
    addr_out  = 6'h2a;
    wdata_out = 8'h5a;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // released lines flip so stale values never look valid
  task automatic idle();
    addr_out  = ~addr_out;
    wdata_out = ~wdata_out;
  endtask : idle
  // one write; strobe stands for exactly one rising edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    idle();
  endtask : wr
  // one read; answer stands in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    idle();
    v = rvalid_in;
    d = rdata_in;
  endtask : rd
  // write, then read the same address on the very next edge
  task automatic wr_rd(input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    idle();
    v = rvalid_in;
    q = rdata_in;
  endtask : wr_rd
endmodule : chop_host
`default_nettype wire

// [tb/chopper_amp_config_register_bench.sv]
`default_nettype none
// ------------------------------------------------------------
// self-checking bench for the chopping config register
// ------------------------------------------------------------
module chopper_amp_config_register_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // short off times keep the run brief
  localparam int unsigned T0 = 5;
  localparam int unsigned T1 = 10;
  localparam int unsigned T2 = 20;
  localparam int unsigned T3 = 40;
  localparam int unsigned BLANK_CYC = 200;  // fixed blanking span
  logic        clk_in  = 1'b0;  // 100 MHz clock
  logic        srst_in = 1'b1;  // reset, held at start
  logic        trip    = 1'b0;  // current above threshold
  logic [5:0]  addr;            // bus address
  logic        wr;              // write strobe
  logic [7:0]  wdata;           // write data
  logic        rd;              // read strobe
  logic [7:0]  rdata;           // read data
  logic        rvalid;          // read answer
  logic [1:0]  chop_off_time;            // off time select
  logic        dis;             // regulation disable
  logic [1:0]  scl;             // reference scale
  logic        sh;              // sample and hold
  logic [1:0]  gain;            // amplifier gain
  logic        off_act;         // off time running
  logic        blank_act;       // blanking running
  int          fails    = 0;    // mismatches
  int          n_checks = 0;    // comparisons
  logic [31:0] seed = 32'hf261; // xorshift state
  wire logic [7:0] fields = {chop_off_time, dis, scl, sh, gain};

  always #5 clk_in = ~clk_in;

  chopper_amp_config_register #(
    .OFF0_CYC(T0), .OFF1_CYC(T1), .OFF2_CYC(T2), .OFF3_CYC(T3)
  ) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .chop_trip_in(trip), .chop_off_time_out(chop_off_time),
    .regulation_disable_out(dis), .vref_scale_out(scl),
    .amp_sample_hold_enable_out(sh), .amp_gain_out(gain),
    .chop_off_active_out(off_act), .chop_blank_active_out(blank_act)
  );

  chop_host i_host (
    .clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid)
  );

  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // off time in cycles for each select code
  function automatic logic [15:0] off_cyc(input logic [1:0] c);
    case (c)
      2'h0:    return 16'(T0);
      2'h1:    return 16'(T1);
      2'h2:    return 16'(T2);
      default: return 16'(T3);
    endcase
  endfunction : off_cyc
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // read one address, expect an answer carrying exp
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.rd(a, d, v);
    chk({7'h00, v, d}, {7'h01, exp});
  endtask : rd_chk
  // count sampled cycles a flag stays high, bounded
  task automatic span(input logic which, output logic [15:0] n);
    n = 16'h0000;
    while ((which ? blank_act : off_act) === 1'b1 && n < 16'h7fff) begin
      n++;
      @(negedge clk_in);
    end
  endtask : span
  // one chop with trip held high through the off time
  task automatic chop_run(input logic [1:0] c);
    logic [15:0] n;
    i_host.wr(6'h05, {c, 6'h01});
    trip = 1'b1;
    @(negedge clk_in);
    chk(16'(off_act), 16'h0001);
    span(1'b0, n);
    chk(n, off_cyc(c));
    chk(16'(blank_act), 16'h0001);
    // trip still high: blanking must run its full length regardless
    span(1'b1, n);
    trip = 1'b0;
    chk(n, 16'(BLANK_CYC));
  endtask : chop_run

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic       v;
    logic [5:0] a;
    int         k;
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    chk(16'(fields), 16'h0001);
    rd_chk(6'h05, 8'h01);
    // every code of every field
    for (k = 0; k < 4; k++) begin
      d = {k[1:0], k[0], k[1:0], k[1], k[1:0]};
      i_host.wr(6'h05, d);
      chk(16'(fields), 16'(d));
      rd_chk(6'h05, d);
    end
    // random traffic; unmapped writes must leave the value alone
    for (k = 0; k < 40; k++) begin
      seed = xs(seed);
      a = seed[9] ? 6'h05 : seed[15:10];
      i_host.wr(a, seed[7:0]);
      if (a == 6'h05) begin
        d = seed[7:0];
      end
      chk(16'(fields), 16'(d));
      rd_chk(6'h05, d);
      rd_chk((seed[21:16] == 6'h05) ? 6'h3f : seed[21:16], 8'h00);
    end
    for (k = 0; k < 4; k++) begin
      chop_run(k[1:0]);
    end
    // trip while regulation is disabled is ignored
    i_host.wr(6'h05, 8'h20);
    trip = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(16'({off_act, blank_act}), 16'h0000);
    trip = 1'b0;
    // disabling in mid-chop drops the sequencer
    i_host.wr(6'h05, 8'hc1);
    trip = 1'b1;
    @(negedge clk_in);
    trip = 1'b0;
    i_host.wr(6'h05, 8'he1);
    @(negedge clk_in);
    chk(16'({off_act, blank_act}), 16'h0000);
    // host puts the overcurrent threshold in the neighbouring register
    i_host.wr(6'h04, 8'h70);
    chk(16'(fields), 16'h00e1);
    // write then read on back-to-back edges
    i_host.wr_rd(6'h05, 8'h96, d, v);
    chk({7'h00, v, d}, 16'h0196);
    // reset in mid-chop restores defaults and idles the sequencer
    i_host.wr(6'h05, 8'hde);
    trip = 1'b1;
    @(negedge clk_in);
    srst_in = 1'b1;
    trip    = 1'b0;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    chk(16'({fields, off_act, blank_act}), 16'h0004);
    rd_chk(6'h05, 8'h01);
    report_and_stop();
  end

  // hang guard: 20k cycles, well past the 1200 or so needed
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : chopper_amp_config_register_bench
`default_nettype wire
